// ===== hdl/irq_status_enable_consts.svh
// Purpose: Register offsets, field positions and reset values of the event request logic
// Assumes: Byte-wide register port, offsets are register indices
// Notes: Definitions only
`ifndef IRQ_STATUS_ENABLE_CONSTS_SVH
`define IRQ_STATUS_ENABLE_CONSTS_SVH

`define OFS_STATUS_PRIMARY 8'h06
`define OFS_STATUS_SECONDARY 8'h07
`define OFS_ENABLE_PRIMARY 8'h08
`define OFS_ENABLE_SECONDARY 8'h09

`define BIT_DIRECTION 7
`define BIT_HIGH_MARK 6
`define BIT_LOW_MARK 5
`define BIT_CMD_DONE 4
`define BIT_TX_DONE 3
`define BIT_RX_DONE 2
`define BIT_ERR_SUM 1
`define BIT_FRAME_START 0

`define BIT_GLOBAL 6
`define BIT_CARD 5
`define BIT_INVERT 7
`define BIT_PIN_GATE 6
`define BIT_PUSH_PULL 7

`define RST_STATUS 8'h00
`define RST_ENABLE 8'h00
`define CMD_IDLE 5'h00

`endif

// ===== hdl/irq_status_enable_pkg.sv
// Purpose: Types of the event request logic
// Assumes: Constants come from the consts header
// Notes: State is one packed struct
package irq_status_enable_pkg;

  typedef struct packed {
    logic [6:0] statusPrimary;
    logic [5:0] statusSecondary;
    logic globalRequest;
    logic [7:0] enablePrimary;
    logic [7:0] enableSecondary;
    logic [7:0] readData;
    logic highLivePrev;
    logic lowLivePrev;
    logic [4:0] commandPrev;
  } state_type;

endpackage

// ===== hdl/irq_status_enable_logic.sv
// Purpose: Sticky event flags, enables and request pin of a reader frontend
// Assumes: Event inputs come from logic on sys_clk; one strobe per cycle
// Notes: Hardware set wins over a software clear in the same cycle
`timescale 1ns/10ps
`include "irq_status_enable_consts.svh"

module irq_status_enable_logic
  import irq_status_enable_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEnable,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // Event sources
  input wire logic fifoHighMarkLive,
  input wire logic fifoLowMarkLive,
  input wire logic [4:0] commandField,
  input wire logic commandByHost,
  input wire logic unknownCommand,
  input wire logic transmitLastBit,
  input wire logic receiveStreamEnd,
  input wire logic fifoWriteError,
  input wire logic fifoOverflowError,
  input wire logic protocolError,
  input wire logic emptyTransmitError,
  input wire logic integrityError,
  input wire logic frameStartSymbol,
  input wire logic subcarrierSeen,
  input wire logic cardDetected,
  input wire logic [4:0] timerUnderflow,
  // Request pin and forced command idle
  output logic requestPinOut,
  output logic requestPinOe_n,
  output logic commandForceIdle
);

  state_type state;
  state_type next_state;

  logic [6:0] hwSetPrimary;
  logic [5:0] hwSetSecondary;
  logic wrStatusPrimary;
  logic wrStatusSecondary;
  logic commandDone;
  logic anyEnabled;
  logic pinLevel;
  logic activeLevel;

  // ------------------------------------------------------------
  // Event capture
  // ------------------------------------------------------------
  assign wrStatusPrimary = regWrite && (regAddr == `OFS_STATUS_PRIMARY);
  assign wrStatusSecondary = regWrite && (regAddr == `OFS_STATUS_SECONDARY);

  // Host-written idle is an abort, not a self termination
  assign commandDone = ((state.commandPrev != `CMD_IDLE) && (commandField == `CMD_IDLE)
                        && !commandByHost) || unknownCommand;
  assign commandForceIdle = unknownCommand;

  always_comb begin
    hwSetPrimary = 7'h00;
    hwSetPrimary[`BIT_HIGH_MARK] = fifoHighMarkLive && !state.highLivePrev;
    hwSetPrimary[`BIT_LOW_MARK] = fifoLowMarkLive && !state.lowLivePrev;
    hwSetPrimary[`BIT_CMD_DONE] = commandDone;
    hwSetPrimary[`BIT_TX_DONE] = transmitLastBit;
    hwSetPrimary[`BIT_RX_DONE] = receiveStreamEnd;
    hwSetPrimary[`BIT_ERR_SUM] = fifoWriteError | fifoOverflowError | protocolError
                                 | emptyTransmitError | integrityError;
    hwSetPrimary[`BIT_FRAME_START] = frameStartSymbol | subcarrierSeen;
    hwSetSecondary = {cardDetected, timerUnderflow};
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.highLivePrev = fifoHighMarkLive;
    next_state.lowLivePrev = fifoLowMarkLive;
    next_state.commandPrev = commandField;
    if (wrStatusPrimary) begin
      if (regWriteData[`BIT_DIRECTION]) begin
        next_state.statusPrimary = state.statusPrimary | regWriteData[6:0];
      end else begin
        next_state.statusPrimary = state.statusPrimary & ~regWriteData[6:0];
      end
    end
    if (wrStatusSecondary) begin
      if (regWriteData[`BIT_DIRECTION]) begin
        next_state.statusSecondary = state.statusSecondary | regWriteData[5:0];
      end else begin
        next_state.statusSecondary = state.statusSecondary & ~regWriteData[5:0];
      end
    end
    // Hardware sets last so they beat a same-cycle clear
    next_state.statusPrimary = next_state.statusPrimary | hwSetPrimary;
    next_state.statusSecondary = next_state.statusSecondary | hwSetSecondary;
    if (regWrite && (regAddr == `OFS_ENABLE_PRIMARY)) begin
      next_state.enablePrimary = regWriteData;
    end
    if (regWrite && (regAddr == `OFS_ENABLE_SECONDARY)) begin
      next_state.enableSecondary = regWriteData;
    end
    // One cycle behind the flags it summarises
    next_state.globalRequest = anyEnabled;
    next_state.readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        `OFS_STATUS_PRIMARY: next_state.readData = {1'b0, state.statusPrimary};
        `OFS_STATUS_SECONDARY: begin
          next_state.readData = {1'b0, state.globalRequest, state.statusSecondary};
        end
        `OFS_ENABLE_PRIMARY: next_state.readData = state.enablePrimary;
        `OFS_ENABLE_SECONDARY: next_state.readData = state.enableSecondary;
        default: next_state.readData = 8'h00;
      endcase
    end
  end

  assign anyEnabled = |(state.statusPrimary & state.enablePrimary[6:0])
                      || |(state.statusSecondary & state.enableSecondary[5:0]);

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state.statusPrimary <= 7'h00;
      state.statusSecondary <= 6'h00;
      state.globalRequest <= 1'b0;
      state.enablePrimary <= `RST_ENABLE;
      state.enableSecondary <= `RST_ENABLE;
      state.readData <= 8'h00;
      state.highLivePrev <= 1'b0;
      state.lowLivePrev <= 1'b0;
      state.commandPrev <= `CMD_IDLE;
    end else if (clkEnable) begin
      state <= next_state;
    end
  end

  assign regReadData = state.readData;

  // ------------------------------------------------------------
  // Request pin
  // ------------------------------------------------------------
  assign activeLevel = state.globalRequest && state.enableSecondary[`BIT_PIN_GATE];
  assign pinLevel = activeLevel ^ state.enablePrimary[`BIT_INVERT];
  // Open drain only pulls low; high is left to the external pull-up
  assign requestPinOut = pinLevel;
  assign requestPinOe_n = state.enableSecondary[`BIT_PUSH_PULL] ? 1'b0 : pinLevel;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence primarySetWrite;
    clkEnable && wrStatusPrimary && regWriteData[`BIT_DIRECTION];
  endsequence

  sequence primaryClearWrite;
    clkEnable && wrStatusPrimary && !regWriteData[`BIT_DIRECTION] && (hwSetPrimary == 7'h00);
  endsequence

  primary_set_a: assert property (primarySetWrite |=>
    ((state.statusPrimary & $past(regWriteData[6:0])) == $past(regWriteData[6:0])))
    else $error("primary set write lost a bit");

  primary_clear_a: assert property (primaryClearWrite |=>
    ((state.statusPrimary & $past(regWriteData[6:0])) == 7'h00))
    else $error("primary clear write left a bit");

  secondary_write_a: assert property (clkEnable && wrStatusSecondary
    && regWriteData[`BIT_DIRECTION] |=> ((state.statusSecondary & $past(regWriteData[5:0]))
    == $past(regWriteData[5:0])))
    else $error("secondary set write lost a bit");

  high_mark_a: assert property (clkEnable && fifoHighMarkLive && !state.highLivePrev
    |=> state.statusPrimary[`BIT_HIGH_MARK])
    else $error("high mark event not latched");

  low_mark_a: assert property (clkEnable && fifoLowMarkLive && !state.lowLivePrev
    |=> state.statusPrimary[`BIT_LOW_MARK])
    else $error("low mark event not latched");

  host_idle_a: assert property (clkEnable && commandByHost && !unknownCommand
    && !(wrStatusPrimary && regWriteData[`BIT_DIRECTION])
    && !state.statusPrimary[`BIT_CMD_DONE] |=> !state.statusPrimary[`BIT_CMD_DONE])
    else $error("host idle set command finished");

  tx_done_a: assert property (clkEnable && transmitLastBit
    |=> state.statusPrimary[`BIT_TX_DONE])
    else $error("transmit done not set");

  error_sum_a: assert property (clkEnable && (fifoWriteError || protocolError
    || integrityError) |=> state.statusPrimary[`BIT_ERR_SUM])
    else $error("error summary not set");

  timer_flag_a: assert property (clkEnable && (timerUnderflow != 5'h00)
    |=> ((state.statusSecondary[4:0] & $past(timerUnderflow)) == $past(timerUnderflow)))
    else $error("timer flag not set");

  global_req_a: assert property (clkEnable && anyEnabled |=> state.globalRequest)
    else $error("global request missed");

  pin_gate_a: assert property (!state.enableSecondary[`BIT_PIN_GATE]
    |-> (requestPinOut == state.enablePrimary[`BIT_INVERT]))
    else $error("pin moved while gated");

  push_pull_a: assert property (state.enableSecondary[`BIT_PUSH_PULL]
    |-> !requestPinOe_n)
    else $error("push pull not driving");

  // ------------------------------------------------------------
  // Checks on flags, request and register port
  // ------------------------------------------------------------
  // Sticky flags only fall through a status write or reset, never on their own

  sequence selfFinish;
    clkEnable && (state.commandPrev != `CMD_IDLE) && (commandField == `CMD_IDLE)
      && !commandByHost;
  endsequence

  sequence statusRead;
    clkEnable && regRead
      && ((regAddr == `OFS_STATUS_PRIMARY) || (regAddr == `OFS_STATUS_SECONDARY));
  endsequence

  sequence secondaryClearWrite;
    clkEnable && wrStatusSecondary && !regWriteData[`BIT_DIRECTION]
      && (hwSetSecondary == 6'h00);
  endsequence

  sequence noEnabledFlag;
    clkEnable && ((state.statusPrimary & state.enablePrimary[6:0]) == 7'h00)
      && ((state.statusSecondary & state.enableSecondary[5:0]) == 6'h00);
  endsequence

  cmd_done_a: assert property (selfFinish
    |=> state.statusPrimary[`BIT_CMD_DONE])
    else $error("self finish not flagged");

  unknown_cmd_a: assert property (clkEnable && unknownCommand
    |=> state.statusPrimary[`BIT_CMD_DONE])
    else $error("unknown command not flagged");

  rx_done_a: assert property (clkEnable && receiveStreamEnd
    |=> state.statusPrimary[`BIT_RX_DONE])
    else $error("receive done not set");

  error_rest_a: assert property (clkEnable && (fifoOverflowError
    || emptyTransmitError) |=> state.statusPrimary[`BIT_ERR_SUM])
    else $error("error summary missed overflow or empty");

  frame_start_a: assert property (clkEnable && (frameStartSymbol
    || subcarrierSeen) |=> state.statusPrimary[`BIT_FRAME_START])
    else $error("frame start not set");

  card_flag_a: assert property (clkEnable && cardDetected
    |=> state.statusSecondary[`BIT_CARD])
    else $error("card detect not set");

  secondary_clear_a: assert property (secondaryClearWrite |=>
    ((state.statusSecondary & $past(regWriteData[5:0])) == 6'h00))
    else $error("secondary clear write left a bit");

  sticky_primary_a: assert property (clkEnable && !wrStatusPrimary
    |=> ((state.statusPrimary & $past(state.statusPrimary))
    == $past(state.statusPrimary)))
    else $error("primary flag fell without a write");

  sticky_second_a: assert property (clkEnable && !wrStatusSecondary
    |=> ((state.statusSecondary & $past(state.statusSecondary))
    == $past(state.statusSecondary)))
    else $error("secondary flag fell without a write");

  invert_pin_a: assert property (state.enableSecondary[`BIT_PIN_GATE]
    |-> (requestPinOut == (state.globalRequest ^ state.enablePrimary[`BIT_INVERT])))
    else $error("pin level wrong while gated on");

  primary_gate_a: assert property (clkEnable
    && ((state.statusPrimary & state.enablePrimary[6:0]) != 7'h00)
    |=> state.globalRequest)
    else $error("enabled primary flag gave no request");

  secondary_gate_a: assert property (clkEnable
    && ((state.statusSecondary & state.enableSecondary[5:0]) != 6'h00)
    |=> state.globalRequest)
    else $error("enabled secondary flag gave no request");

  request_drop_a: assert property (noEnabledFlag |=> !state.globalRequest)
    else $error("request stayed without enabled flag");

  reset_clear_a: assert property (disable iff (1'b0) srst
    |=> (state.statusPrimary == 7'h00))
    else $error("reset left a primary flag");

  open_drain_a: assert property (!state.enableSecondary[`BIT_PUSH_PULL]
    |-> (requestPinOe_n == requestPinOut))
    else $error("open drain drove a high level");

  dir_read_a: assert property (statusRead |=> !regReadData[`BIT_DIRECTION])
    else $error("direction bit read back");

  primary_read_a: assert property (clkEnable && regRead
    && (regAddr == `OFS_STATUS_PRIMARY)
    |=> (regReadData == {1'b0, $past(state.statusPrimary)}))
    else $error("primary status read wrong");

  secondary_read_a: assert property (clkEnable && regRead
    && (regAddr == `OFS_STATUS_SECONDARY)
    |=> (regReadData == {1'b0, $past(state.globalRequest), $past(state.statusSecondary)}))
    else $error("secondary status read wrong");

  enable_write_a: assert property (clkEnable && regWrite
    && (regAddr == `OFS_ENABLE_PRIMARY)
    |=> (state.enablePrimary == $past(regWriteData)))
    else $error("primary enable write lost");

  enable2_write_a: assert property (clkEnable && regWrite
    && (regAddr == `OFS_ENABLE_SECONDARY)
    |=> (state.enableSecondary == $past(regWriteData)))
    else $error("secondary enable write lost");

  // Read data must not linger, a stale byte would look like a fresh read
  read_idle_a: assert property (clkEnable && !regRead |=> (regReadData == 8'h00))
    else $error("read data outside its cycle");

  freeze_a: assert property (!clkEnable |=> (state == $past(state)))
    else $error("state moved while clock enable low");

endmodule

// ===== tb/host_pin_model.sv
// Purpose: Host side of the request pin, resolves the wire level
// Assumes: Board pull-up on the request line
// Notes: Released line reads high, never the last driven value
`timescale 1ns/10ps

module host_pin_model (
  // Pin from the device
  input wire logic pinOut,
  input wire logic pinOe_n,
  // Level seen by the host
  output logic pinLevel
);
  // Open-drain release floats to the pull-up
  assign pinLevel = pinOe_n ? 1'b1 : pinOut;
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the event request logic
// Assumes: Register port answers one cycle after a read strobe
// Notes: Every event source but the command field is pulsed through one table
`timescale 1ns/10ps
`include "irq_status_enable_consts.svh"

module testbench;
  logic sys_clk = 0;
  logic srst = 1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 0;
  logic regRead = 0;
  logic clkEnable = 1;
  logic [17:0] ev = 18'h00000;
  logic [4:0] commandField = 5'h00;
  logic commandByHost = 0;
  logic [7:0] regReadData;
  logic requestPinOut, requestPinOe_n, commandForceIdle, pinLevel;
  int errTotal = 0;
  int cmpCount = 0;
  int bitOf [18] = '{0, 0, 1, 1, 1, 1, 1, 2, 3, 4, 5, 6, 0, 1, 2, 3, 4, 5};
  logic [7:0] d;

  always #10 sys_clk = ~sys_clk;

  irq_status_enable_logic dut (.sys_clk(sys_clk), .srst(srst), .clkEnable(clkEnable),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .fifoHighMarkLive(ev[11]),
    .fifoLowMarkLive(ev[10]), .commandField(commandField),
    .commandByHost(commandByHost), .unknownCommand(ev[9]), .transmitLastBit(ev[8]),
    .receiveStreamEnd(ev[7]), .fifoWriteError(ev[2]), .fifoOverflowError(ev[3]),
    .protocolError(ev[4]), .emptyTransmitError(ev[5]), .integrityError(ev[6]),
    .frameStartSymbol(ev[0]), .subcarrierSeen(ev[1]), .cardDetected(ev[17]),
    .timerUnderflow(ev[16:12]), .requestPinOut(requestPinOut),
    .requestPinOe_n(requestPinOe_n), .commandForceIdle(commandForceIdle));

  host_pin_model host (.pinOut(requestPinOut), .pinOe_n(requestPinOe_n),
    .pinLevel(pinLevel));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1;
    @(posedge sys_clk);
    regWrite <= 0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1;
    @(posedge sys_clk);
    regRead <= 0;
    #1 v = regReadData;
  endtask

  task settle;
    repeat (3) @(posedge sys_clk);
  endtask

  task pin(input logic lvl);
    settle();
    check({7'h00, pinLevel}, {7'h00, lvl});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_reset;
    rd(`OFS_STATUS_PRIMARY, d); check(d, `RST_STATUS);
    rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h00);
    rd(`OFS_ENABLE_PRIMARY, d); check(d, `RST_ENABLE);
    rd(`OFS_ENABLE_SECONDARY, d); check(d, `RST_ENABLE);
    rd(8'h0b, d); check(d, 8'h00);
    $display("test_reset done");
  endtask

  task test_direction;
    wr(`OFS_STATUS_PRIMARY, 8'hff); rd(`OFS_STATUS_PRIMARY, d); check(d, 8'h7f);
    wr(`OFS_STATUS_PRIMARY, 8'h7e); rd(`OFS_STATUS_PRIMARY, d); check(d, 8'h01);
    wr(`OFS_STATUS_PRIMARY, 8'h7f); rd(`OFS_STATUS_PRIMARY, d); check(d, 8'h00);
    wr(`OFS_STATUS_SECONDARY, 8'hff); rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h3f);
    wr(`OFS_STATUS_SECONDARY, 8'h21); rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h1e);
    wr(`OFS_STATUS_SECONDARY, 8'h7f); rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h00);
    $display("test_direction done");
  endtask

  task test_events;
    logic [7:0] a;
    for (int i = 0; i < 18; i++) begin
      a = (i < 12) ? `OFS_STATUS_PRIMARY : `OFS_STATUS_SECONDARY;
      @(posedge sys_clk);
      ev[i] <= 1;
      #1 if (i == 9) check({7'h00, commandForceIdle}, 8'h01);
      @(posedge sys_clk);
      ev[i] <= 0;
      rd(a, d); check(d, 8'h01 << bitOf[i]);
      wr(a, 8'h7f); rd(a, d); check(d, 8'h00);
    end
    $display("test_events done");
  endtask

  task test_command;
    for (int h = 0; h < 2; h++) begin
      @(posedge sys_clk);
      commandByHost <= h[0];
      commandField <= 5'h03;
      repeat (2) @(posedge sys_clk);
      commandField <= `CMD_IDLE;
      rd(`OFS_STATUS_PRIMARY, d); check(d, h ? 8'h00 : 8'h10);
      wr(`OFS_STATUS_PRIMARY, 8'h7f);
    end
    commandByHost <= 0;
    $display("test_command done");
  endtask

  task test_request;
    wr(`OFS_ENABLE_PRIMARY, 8'h04); wr(`OFS_STATUS_PRIMARY, 8'h84); settle();
    rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h40);
    pin(0);
    wr(`OFS_ENABLE_SECONDARY, 8'h40); pin(1);
    check({7'h00, requestPinOe_n}, 8'h01);
    wr(`OFS_ENABLE_PRIMARY, 8'h84); pin(0);
    wr(`OFS_ENABLE_SECONDARY, 8'hc0); wr(`OFS_ENABLE_PRIMARY, 8'h04); pin(1);
    check({7'h00, requestPinOe_n}, 8'h00);
    wr(`OFS_ENABLE_PRIMARY, 8'h00); settle();
    rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h00);
    pin(0);
    wr(`OFS_ENABLE_SECONDARY, 8'hc1); wr(`OFS_STATUS_SECONDARY, 8'h81); settle();
    rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h41);
    pin(1);
    wr(`OFS_STATUS_SECONDARY, 8'h01); settle();
    rd(`OFS_STATUS_SECONDARY, d); check(d, 8'h00);
    pin(0);
    $display("test_request done");
  endtask

  task test_freeze_reset;
    wr(`OFS_ENABLE_SECONDARY, 8'h3f); rd(`OFS_ENABLE_SECONDARY, d); check(d, 8'h3f);
    @(posedge sys_clk);
    clkEnable <= 0;
    regAddr <= `OFS_STATUS_PRIMARY;
    regWriteData <= 8'hff;
    regWrite <= 1;
    @(posedge sys_clk);
    regWrite <= 0;
    clkEnable <= 1;
    rd(`OFS_STATUS_PRIMARY, d); check(d, 8'h04);
    @(posedge sys_clk);
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    rd(`OFS_STATUS_PRIMARY, d); check(d, `RST_STATUS);
    rd(`OFS_ENABLE_SECONDARY, d); check(d, `RST_ENABLE);
    pin(0);
    $display("test_freeze_reset done");
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 0;
    test_reset();
    test_direction();
    test_events();
    test_command();
    test_request();
    test_freeze_reset();
    print_verdict();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #40000;
    errTotal++;
    print_verdict();
  end
endmodule
